// *** pkg/tofc_pkg.sv ***
// Constants shared by the thermal offset and overtemp fan policy register bank
package tofc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] TOFC_IDX_LOCAL_OFS  = 8'h0d;
    localparam logic [7:0] TOFC_IDX_REMOTE_OFS = 8'h0e;
    localparam logic [7:0] TOFC_IDX_POLICY_REV = 8'h3f;
    localparam logic [7:0] TOFC_IDX_LOCAL_RD   = 8'h40;
    localparam logic [7:0] TOFC_IDX_REMOTE_RD  = 8'h41;
    localparam logic [7:0] TOFC_IDX_PIN_STAT   = 8'h42;

    // Field positions
    localparam int TOFC_POS_DIR      = 7;
    localparam int TOFC_POS_FORCE    = 7;
    localparam int TOFC_POS_RSV_HI   = 6;
    localparam int TOFC_POS_RSV_LO   = 4;
    localparam int TOFC_POS_MAG_HI   = 3;
    localparam int TOFC_POS_REV_HI   = 3;

    // Reset values
    localparam logic [7:0] TOFC_RST_LOCAL_OFS  = 8'h00;
    localparam logic [7:0] TOFC_RST_REMOTE_OFS = 8'h00;
    localparam logic [7:0] TOFC_RST_POLICY_REV = 8'h80;

    // Silicon revision nibble; value is arbitrary
    localparam logic [3:0] TOFC_REVISION = 4'h1;

    // Reading formats: signed whole degrees plus fraction bits
    localparam int TOFC_LOCAL_FRAC  = 2;
    localparam int TOFC_REMOTE_FRAC = 3;
    localparam int TOFC_LOCAL_W     = 8 + TOFC_LOCAL_FRAC;
    localparam int TOFC_REMOTE_W    = 8 + TOFC_REMOTE_FRAC;

    // AHB-Lite encodings
    localparam logic [1:0] TOFC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TOFC_HTRANS_SEQ    = 2'h3;
    localparam logic       TOFC_HRESP_OKAY    = 1'h0;

    // Bus slave states
    typedef enum logic [1:0] {
        TOFC_BUS_IDLE  = 2'h0,
        TOFC_BUS_WRITE = 2'h1,
        TOFC_BUS_READ  = 2'h2
    } tofc_bus_state_type;

endpackage

// *** rtl/tofc_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/1ps
`default_nettype none

module tofc_pin_sync (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic pin_i,
    output logic      level_o
);

    logic meta;
    logic stage2;
    logic stage3;
    logic agree;

    // Level moves only when the second and third stages agree
    assign agree = (stage2 == stage3);

    // First stage is read only by the second stage; idle level is high
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta    <= 1'h1;
            stage2  <= 1'h1;
            stage3  <= 1'h1;
            level_o <= 1'h1;
        end else if (ce_i) begin
            meta   <= pin_i;
            stage2 <= meta;
            stage3 <= stage2;
            if (agree) begin
                level_o <= stage3;
            end
        end
    end

endmodule

`default_nettype wire

// *** rtl/tofc_reading_adjust.sv ***
// Applies a signed whole-degree offset to a fixed-point reading, saturating
`timescale 1ns/1ps
`default_nettype none

module tofc_reading_adjust #(
    parameter int W    = 10,
    parameter int FRAC = 2
) (
    input  wire logic [W-1:0] raw_i,
    input  wire logic         dir_i,
    input  wire logic [3:0]   mag_i,
    output logic [W-1:0]      adj_o
);

    logic signed [W+1:0] raw_ext;
    logic signed [W+1:0] ofs_ext;
    logic signed [W+1:0] sum;

    // Clamp to the signed range of the reading instead of wrapping round
    function automatic logic [W-1:0] sat(input logic signed [W+1:0] v);
        logic signed [W+1:0] max_v;
        logic signed [W+1:0] min_v;
        max_v = (W+2)'((1 <<< (W-1)) - 1);
        min_v = -(W+2)'(1 <<< (W-1));
        if (v > max_v) begin
            sat = max_v[W-1:0];
        end else if (v < min_v) begin
            sat = min_v[W-1:0];
        end else begin
            sat = v[W-1:0];
        end
    endfunction

    // Magnitude is in whole degrees, so it sits above the fraction bits
    assign raw_ext = {{2{raw_i[W-1]}}, raw_i};
    assign ofs_ext = (W+2)'({mag_i, {FRAC{1'b0}}});
    assign sum     = dir_i ? (raw_ext - ofs_ext) : (raw_ext + ofs_ext);
    assign adj_o   = sat(sum);

endmodule

`default_nettype wire

// *** rtl/tofc_reg_bank.sv ***
// Offset and overtemp fan policy register bank with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Force bit and own overtemp drive: full fan
// - Force bit clear: no full fan on overtemp
// - External low on overtemp pin: bit ignored
// - Policy register at 0x3f, resets to 0x80
// - Policy bits six to four read zero
// - Low nibble is revision, writes ignored
// - Local direction bit: 0 adds, 1 subtracts
// - Local four-bit offset, up to 15 degrees
// - Remote direction bit: 0 adds, 1 subtracts
// - Remote four-bit offset, up to 15 degrees
// - Offset bits six to four writable reserved
// - Local offset at 0x0d, resets to zero
// - Remote offset at 0x0e, resets to zero
module tofc_reg_bank
    import tofc_pkg::*;
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     ce_i,
    // AHB-Lite slave
    input  wire logic                     hsel_i,
    input  wire logic [31:0]              haddr_i,
    input  wire logic [1:0]               htrans_i,
    input  wire logic                     hwrite_i,
    input  wire logic [2:0]               hsize_i,
    input  wire logic [31:0]              hwdata_i,
    input  wire logic                     hready_i,
    output logic [31:0]                   hrdata_o,
    output logic                          hreadyout_o,
    output logic                          hresp_o,
    // Raw readings from the converter
    input  wire logic [TOFC_LOCAL_W-1:0]  local_raw_i,
    input  wire logic                     local_raw_valid_i,
    input  wire logic [TOFC_REMOTE_W-1:0] remote_raw_i,
    input  wire logic                     remote_raw_valid_i,
    // Corrected readings to the fan loop and alarm comparators
    output logic [TOFC_LOCAL_W-1:0]       local_corr_o,
    output logic [TOFC_REMOTE_W-1:0]      remote_corr_o,
    // Overtemp request from the device's own comparators
    input  wire logic                     overtemp_req_i,
    // Open-drain overtemp pin
    input  wire logic                     overtemp_pin_i,
    output logic                          overtemp_pin_o,
    output logic                          overtemp_pin_oe_o,
    // Fan control
    output logic                          fan_full_speed_o
);

    // Register storage: only the writable bits are kept
    logic                      local_dir;
    logic [2:0]                local_rsv;
    logic [3:0]                local_mag;
    logic                      remote_dir;
    logic [2:0]                remote_rsv;
    logic [3:0]                remote_mag;
    logic                      fan_force;

    // Bus pipeline
    tofc_bus_state_type        bus_state;
    logic [7:0]                bus_idx;
    logic                      bus_lane0;

    // Pin state
    logic                      pin_level;
    logic                      ext_low;
    logic [3:0]                oe_trail;

    // Next values of the stored bits
    logic                      next_local_dir;
    logic [2:0]                next_local_rsv;
    logic [3:0]                next_local_mag;
    logic                      next_remote_dir;
    logic [2:0]                next_remote_rsv;
    logic [3:0]                next_remote_mag;
    logic                      next_fan_force;
    logic                      next_fan_full;

    // Decode wires
    wire logic                 addr_valid;
    wire logic                 addr_take;
    wire logic [7:0]           addr_idx;
    wire logic                 addr_lane0;
    wire logic                 wr_commit;
    wire logic                 wr_local;
    wire logic                 wr_remote;
    wire logic                 wr_policy;
    wire logic [7:0]           wr_byte;
    wire logic [7:0]           rd_byte;
    wire logic [31:0]          next_rdata;

    // Corrected values from the adjusters
    wire logic [TOFC_LOCAL_W-1:0]  local_adj;
    wire logic [TOFC_REMOTE_W-1:0] remote_adj;

    // Byte view of an offset register for read-back
    function automatic logic [7:0] ofs_byte(
        input logic       dir,
        input logic [2:0] rsv,
        input logic [3:0] mag
    );
        ofs_byte = {dir, rsv, mag};
    endfunction

    // Index from a byte address; the low two bits are dropped, so every byte of a word maps to its register
    function automatic logic [7:0] idx_of(input logic [31:0] addr);
        idx_of = addr[9:2];
    endfunction

    // ---------------------------------------------------------------
    // Address phase decode
    // ---------------------------------------------------------------

    // A transfer is taken when selected, active, the bus is ready and ce_i is high
    assign addr_valid = hsel_i
                        && ((htrans_i == TOFC_HTRANS_NONSEQ)
                            || (htrans_i == TOFC_HTRANS_SEQ));
    assign addr_take  = addr_valid && hready_i && ce_i;
    assign addr_idx   = (haddr_i[31:10] == 22'h000000)
                        ? idx_of(haddr_i) : 8'hff;
    // Narrow writes touch the register only if they cover byte lane 0
    assign addr_lane0 = (haddr_i[1:0] == 2'h0)
                        || (hsize_i == 3'h2 && haddr_i[1:0] == 2'h0);

    // ---------------------------------------------------------------
    // Data phase write decode
    // ---------------------------------------------------------------

    // Writes land at the end of the data phase, when hwdata stands
    assign wr_commit = (bus_state == TOFC_BUS_WRITE) && bus_lane0 && ce_i;
    assign wr_local  = wr_commit && (bus_idx == TOFC_IDX_LOCAL_OFS);
    assign wr_remote = wr_commit && (bus_idx == TOFC_IDX_REMOTE_OFS);
    assign wr_policy = wr_commit && (bus_idx == TOFC_IDX_POLICY_REV);
    assign wr_byte   = hwdata_i[7:0];

    // ---------------------------------------------------------------
    // Next register values
    // ---------------------------------------------------------------

    // Offset registers: direction, reserved and magnitude all writable
    always_comb begin
        next_local_dir  = local_dir;
        next_local_rsv  = local_rsv;
        next_local_mag  = local_mag;
        next_remote_dir = remote_dir;
        next_remote_rsv = remote_rsv;
        next_remote_mag = remote_mag;
        if (wr_local) begin
            next_local_dir = wr_byte[TOFC_POS_DIR];
            next_local_rsv = wr_byte[TOFC_POS_RSV_HI:TOFC_POS_RSV_LO];
            next_local_mag = wr_byte[TOFC_POS_MAG_HI:0];
        end
        if (wr_remote) begin
            next_remote_dir = wr_byte[TOFC_POS_DIR];
            next_remote_rsv = wr_byte[TOFC_POS_RSV_HI:TOFC_POS_RSV_LO];
            next_remote_mag = wr_byte[TOFC_POS_MAG_HI:0];
        end
    end

    // Policy register keeps only the force bit; the rest is fixed
    always_comb begin
        next_fan_force = fan_force;
        if (wr_policy) begin
            next_fan_force = wr_byte[TOFC_POS_FORCE];
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------

    // Read uses next values so a read right after a write sees it
    assign rd_byte =
        (addr_idx == TOFC_IDX_LOCAL_OFS)
            ? ofs_byte(next_local_dir, next_local_rsv, next_local_mag) :
        (addr_idx == TOFC_IDX_REMOTE_OFS)
            ? ofs_byte(next_remote_dir, next_remote_rsv, next_remote_mag) :
        (addr_idx == TOFC_IDX_POLICY_REV)
            ? {next_fan_force, 3'h0, TOFC_REVISION} :
        (addr_idx == TOFC_IDX_PIN_STAT)
            ? {5'h00, ext_low, overtemp_pin_oe_o, pin_level} :
        8'h00;

    // Wider corrected readings are read whole, sign-extended
    assign next_rdata =
        (addr_idx == TOFC_IDX_LOCAL_RD)
            ? {{(32-TOFC_LOCAL_W){local_corr_o[TOFC_LOCAL_W-1]}},
               local_corr_o} :
        (addr_idx == TOFC_IDX_REMOTE_RD)
            ? {{(32-TOFC_REMOTE_W){remote_corr_o[TOFC_REMOTE_W-1]}},
               remote_corr_o} :
        {24'h000000, rd_byte};

    // ---------------------------------------------------------------
    // Bus slave state
    // ---------------------------------------------------------------

    // Zero wait states: hreadyout rises after reset and stays high
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_state   <= TOFC_BUS_IDLE;
            bus_idx     <= 8'h00;
            bus_lane0   <= 1'h0;
            hreadyout_o <= 1'h0;
            hresp_o     <= TOFC_HRESP_OKAY;
        end else if (ce_i) begin
            hreadyout_o <= 1'h1;
            hresp_o     <= TOFC_HRESP_OKAY;
            if (hready_i) begin
                if (addr_take) begin
                    bus_state <= hwrite_i ? TOFC_BUS_WRITE : TOFC_BUS_READ;
                    bus_idx   <= addr_idx;
                    bus_lane0 <= addr_lane0;
                end else begin
                    bus_state <= TOFC_BUS_IDLE;
                end
            end
        end
    end

    // Read data is latched at the address edge and stands through the data phase
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h00000000;
        end else if (addr_take && !hwrite_i) begin
            hrdata_o <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------

    // Offset registers power up clear, so no correction applies
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            local_dir  <= TOFC_RST_LOCAL_OFS[TOFC_POS_DIR];
            local_rsv  <= TOFC_RST_LOCAL_OFS[TOFC_POS_RSV_HI:TOFC_POS_RSV_LO];
            local_mag  <= TOFC_RST_LOCAL_OFS[TOFC_POS_MAG_HI:0];
            remote_dir <= TOFC_RST_REMOTE_OFS[TOFC_POS_DIR];
            remote_rsv <= TOFC_RST_REMOTE_OFS[TOFC_POS_RSV_HI:TOFC_POS_RSV_LO];
            remote_mag <= TOFC_RST_REMOTE_OFS[TOFC_POS_MAG_HI:0];
        end else if (ce_i) begin
            local_dir  <= next_local_dir;
            local_rsv  <= next_local_rsv;
            local_mag  <= next_local_mag;
            remote_dir <= next_remote_dir;
            remote_rsv <= next_remote_rsv;
            remote_mag <= next_remote_mag;
        end
    end

    // Force bit powers up set: performance mode by default
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fan_force <= TOFC_RST_POLICY_REV[TOFC_POS_FORCE];
        end else if (ce_i) begin
            fan_force <= next_fan_force;
        end
    end

    // ---------------------------------------------------------------
    // Reading correction
    // ---------------------------------------------------------------

    // One adjuster per channel; both share the same saturating arithmetic
    tofc_reading_adjust #(
        .W    (TOFC_LOCAL_W),
        .FRAC (TOFC_LOCAL_FRAC)
    ) u_local_adj (
        .raw_i (local_raw_i),
        .dir_i (local_dir),
        .mag_i (local_mag),
        .adj_o (local_adj)
    );

    tofc_reading_adjust #(
        .W    (TOFC_REMOTE_W),
        .FRAC (TOFC_REMOTE_FRAC)
    ) u_remote_adj (
        .raw_i (remote_raw_i),
        .dir_i (remote_dir),
        .mag_i (remote_mag),
        .adj_o (remote_adj)
    );

    // Corrected values refresh on each new sample; an offset change waits
    // for the next sample so the fan loop never sees a half-old value
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            local_corr_o  <= '0;
            remote_corr_o <= '0;
        end else if (ce_i) begin
            if (local_raw_valid_i) begin
                local_corr_o <= local_adj;
            end
            if (remote_raw_valid_i) begin
                remote_corr_o <= remote_adj;
            end
        end
    end

    // ---------------------------------------------------------------
    // Overtemp pin and fan policy
    // ---------------------------------------------------------------

    // Pin comes from outside the clock domain
    tofc_pin_sync u_pin_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .pin_i     (overtemp_pin_i),
        .level_o   (pin_level)
    );

    // Full speed only for our own drive; an external low is not ours
    always_comb begin
        next_fan_full = 1'h0;
        if (fan_force && overtemp_req_i) begin
            next_fan_full = 1'h1;
        end
        if (!fan_force) begin
            next_fan_full = 1'h0;
        end
    end

    // Open-drain drive: output level is always low, enable when asserted
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overtemp_pin_o    <= 1'h0;
            overtemp_pin_oe_o <= 1'h0;
            fan_full_speed_o  <= 1'h0;
            ext_low           <= 1'h0;
            oe_trail          <= 4'h0;
        end else if (ce_i) begin
            overtemp_pin_o    <= 1'h0;
            overtemp_pin_oe_o <= overtemp_req_i;
            fan_full_speed_o  <= next_fan_full;
            // Own drive echoes through the synchroniser for four edges after release
            oe_trail          <= {oe_trail[2:0], overtemp_pin_oe_o};
            // Pin low while we are not driving it is an outside pull
            ext_low           <= !pin_level && !overtemp_pin_oe_o && (oe_trail == 4'h0);
        end
    end

endmodule

`default_nettype wire

// *** sim/tofc_reg_bank_sva.sv ***
// Checker for bus answers, overtemp drive and corrected readings of the register bank
`timescale 1ns/1ps
`default_nettype none
module tofc_reg_bank_sva
    import tofc_pkg::*;
(
    input wire logic                     clk_sys_i,
    input wire logic                     rst_n_i,
    input wire logic                     ce_i,
    input wire logic                     hsel_i,
    input wire logic [31:0]              haddr_i,
    input wire logic [1:0]               htrans_i,
    input wire logic                     hwrite_i,
    input wire logic                     hready_i,
    input wire logic [31:0]              hrdata_o,
    input wire logic                     hreadyout_o,
    input wire logic                     hresp_o,
    input wire logic                     local_raw_valid_i,
    input wire logic                     remote_raw_valid_i,
    input wire logic [TOFC_LOCAL_W-1:0]  local_corr_o,
    input wire logic [TOFC_REMOTE_W-1:0] remote_corr_o,
    input wire logic                     overtemp_req_i,
    input wire logic                     overtemp_pin_o,
    input wire logic                     overtemp_pin_oe_o,
    input wire logic                     fan_full_speed_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Read address phases accepted at this edge, by register
    wire rd_take   = hsel_i && htrans_i[1] && !hwrite_i && hready_i && ce_i;
    wire rd_policy = rd_take && (haddr_i == {22'h0, TOFC_IDX_POLICY_REV, 2'h0});
    wire rd_offset = rd_take && (haddr_i == {22'h0, TOFC_IDX_LOCAL_OFS, 2'h0} ||
                                 haddr_i == {22'h0, TOFC_IDX_REMOTE_OFS, 2'h0});

    // A pin pulled low from outside must never reach the fan
    property p_fan_needs_req; fan_full_speed_o |-> $past(overtemp_req_i); endproperty
    a_fan_needs_req: assert property (p_fan_needs_req) else $error("fan forced without own request");
    property p_oe_follow; $past(ce_i) |-> overtemp_pin_oe_o == $past(overtemp_req_i); endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("pin drive does not follow request");
    property p_pin_low; overtemp_pin_oe_o |-> !overtemp_pin_o; endproperty
    a_pin_low: assert property (p_pin_low) else $error("overtemp pin driven high");
    property p_ready; $past(rst_n_i) && $past(ce_i) |-> hreadyout_o && hresp_o == TOFC_HRESP_OKAY; endproperty
    a_ready: assert property (p_ready) else $error("wait state or error response");
    property p_policy_rsv; rd_policy |=> hrdata_o[6:4] == 3'h0; endproperty
    a_policy_rsv: assert property (p_policy_rsv) else $error("policy unused bits not zero");
    property p_policy_rev; rd_policy |=> hrdata_o[3:0] == TOFC_REVISION; endproperty
    a_policy_rev: assert property (p_policy_rev) else $error("revision nibble wrong");
    property p_ofs_upper; rd_offset |=> hrdata_o[31:8] == 24'h0; endproperty
    a_ofs_upper: assert property (p_ofs_upper) else $error("offset upper bits not zero");
    property p_local_hold; !local_raw_valid_i |=> $stable(local_corr_o); endproperty
    a_local_hold: assert property (p_local_hold) else $error("local reading moved without sample");
    property p_remote_hold; !remote_raw_valid_i |=> $stable(remote_corr_o); endproperty
    a_remote_hold: assert property (p_remote_hold) else $error("remote reading moved without sample");
endmodule

bind tofc_reg_bank tofc_reg_bank_sva u_sva (.clk_sys_i, .rst_n_i, .ce_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .local_raw_valid_i, .remote_raw_valid_i, .local_corr_o,
    .remote_corr_o, .overtemp_req_i, .overtemp_pin_o, .overtemp_pin_oe_o, .fan_full_speed_o);
`default_nettype wire

// *** sim/tofc_reg_bank_tb.sv ***
// Self-checking bench for the offset and overtemp fan policy register bank
`timescale 1ns/1ps
`default_nettype none
module tofc_reg_bank_tb
    import tofc_pkg::*;
;
    logic                     clk_sys_i, rst_n_i, ce_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic [31:0]              haddr_i, hwdata_i, hrdata_o;
    logic [1:0]               htrans_i;
    logic [2:0]               hsize_i;
    logic                     overtemp_req_i, overtemp_pin_o, overtemp_pin_oe_o, fan_full_speed_o;
    logic                     local_raw_valid_i, remote_raw_valid_i, ext_low;
    logic [TOFC_LOCAL_W-1:0]  local_raw_i, local_corr_o, lr;
    logic [TOFC_REMOTE_W-1:0] remote_raw_i, remote_corr_o, rr;
    logic [7:0]               lo, ro;
    logic                     rd_dphase = 1'b0;
    typedef struct {string name; logic [31:0] exp;} tofc_note_type;
    tofc_note_type            notes[$];
    int                       num_errors, compares, seed, cycles;
    wire                      hready_i = hreadyout_o;
    // Open-drain wire with pull-up: low if the block or the outside world pulls it
    wire                      overtemp_pin_i = !((overtemp_pin_oe_o && !overtemp_pin_o) || ext_low);

    tofc_reg_bank DUT (.clk_sys_i, .rst_n_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .local_raw_i, .local_raw_valid_i,
        .remote_raw_i, .remote_raw_valid_i, .local_corr_o, .remote_corr_o, .overtemp_req_i,
        .overtemp_pin_i, .overtemp_pin_o, .overtemp_pin_oe_o, .fan_full_speed_o);

    always #2 clk_sys_i = ~clk_sys_i;

    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [31:0] ad(input logic [7:0] idx);
        return {22'h0, idx, 2'h0};
    endfunction

    // Sign-magnitude whole-degree offset, saturated to the reading's signed range
    function automatic logic [31:0] corr(input int raw, input int frac, input int w, input logic [7:0] ofs);
        int v;
        int hi;
        v = raw + (ofs[7] ? -1 : 1) * (int'(ofs[3:0]) << frac);
        hi = (1 << (w - 1)) - 1;
        if (v > hi) v = hi;
        if (v < -hi - 1) v = -hi - 1;
        return 32'(v);
    endfunction

    task automatic wait_ready();
        @(posedge clk_sys_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    endtask

    // One single word transfer; the answer is awaited, never assumed
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] d);
        hsel_i <= 1'b1;
        haddr_i <= addr;
        htrans_i <= TOFC_HTRANS_NONSEQ;
        hwrite_i <= wr;
        wait_ready();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wait_ready();
    endtask

    task automatic rd(input string name, input logic [31:0] addr, input logic [31:0] exp);
        notes.push_back('{name, exp});
        bus(1'b0, addr, 32'h0);
    endtask

    // Watcher: read data is taken at the edge that ends the data phase
    always @(posedge clk_sys_i) begin
        if (rd_dphase && hreadyout_o === 1'b1 && notes.size() > 0) begin
            check(notes[0].name, notes[0].exp, hrdata_o);
            void'(notes.pop_front());
        end
        rd_dphase <= hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o;
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        {clk_sys_i, rst_n_i, hsel_i, hwrite_i, overtemp_req_i, ext_low} = '0;
        {local_raw_valid_i, remote_raw_valid_i, haddr_i, hwdata_i, htrans_i} = '0;
        {local_raw_i, remote_raw_i} = '0;
        ce_i = 1'b1;
        hsize_i = 3'h2;
        seed = 94;
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        for (int k = 0; k < 2; k++) begin
            rd("local ofs", ad(TOFC_IDX_LOCAL_OFS), 32'h0);
            rd("remote ofs", ad(TOFC_IDX_REMOTE_OFS), 32'h0);
            rd("policy", ad(TOFC_IDX_POLICY_REV), {24'h0, 4'h8, TOFC_REVISION});
            bus(1'b1, ad(TOFC_IDX_POLICY_REV), 32'h7f);
            rd("policy ro", ad(TOFC_IDX_POLICY_REV), {24'h0, 4'h0, TOFC_REVISION});
            bus(1'b1, ad(TOFC_IDX_LOCAL_OFS), 32'h75);
            rd("local rsv", ad(TOFC_IDX_LOCAL_OFS), 32'h75);
            bus(1'b1, ad(TOFC_IDX_REMOTE_OFS), 32'hf0);
            rd("remote rsv", ad(TOFC_IDX_REMOTE_OFS), 32'hf0);
            bus(1'b1, 32'h200, 32'hff);
            rd("unmapped", 32'h200, 32'h0);
            // Second pass starts from a reset in mid-run
            rst_n_i <= 1'b0;
            @(posedge clk_sys_i);
            rst_n_i <= 1'b1;
            repeat (2) @(posedge clk_sys_i);
        end
        // Random offsets and readings; the first two hit saturation at both ends
        for (int i = 0; i < 10; i++) begin
            lo = (i == 0) ? 8'h0f : 8'($random(seed)) & 8'h8f;
            ro = (i == 1) ? 8'h8f : 8'($random(seed)) & 8'h8f;
            lr = (i == 0) ? 10'h1ff : 10'($random(seed));
            rr = (i == 1) ? 11'h400 : 11'($random(seed));
            bus(1'b1, ad(TOFC_IDX_LOCAL_OFS), {24'h0, lo});
            bus(1'b1, ad(TOFC_IDX_REMOTE_OFS), {24'h0, ro});
            local_raw_i <= lr;
            remote_raw_i <= rr;
            local_raw_valid_i <= 1'b1;
            remote_raw_valid_i <= 1'b1;
            @(posedge clk_sys_i);
            local_raw_valid_i <= 1'b0;
            remote_raw_valid_i <= 1'b0;
            rd("local corr", ad(TOFC_IDX_LOCAL_RD), corr($signed(lr), TOFC_LOCAL_FRAC, TOFC_LOCAL_W, lo));
            rd("remote corr", ad(TOFC_IDX_REMOTE_RD), corr($signed(rr), TOFC_REMOTE_FRAC, TOFC_REMOTE_W, ro));
        end
        // Fan policy against own request and an outside pull on the pin
        bus(1'b1, ad(TOFC_IDX_POLICY_REV), 32'h80);
        // Clock enable low: the request must not reach the fan until it rises
        ce_i <= 1'b0;
        overtemp_req_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        check("fan frozen", 32'h0, {31'h0, fan_full_speed_o});
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        check("fan forced", 32'h1, {31'h0, fan_full_speed_o});
        bus(1'b1, ad(TOFC_IDX_POLICY_REV), 32'h00);
        repeat (2) @(posedge clk_sys_i);
        check("fan silent", 32'h0, {31'h0, fan_full_speed_o});
        overtemp_req_i <= 1'b0;
        bus(1'b1, ad(TOFC_IDX_POLICY_REV), 32'h80);
        ext_low <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        check("fan external", 32'h0, {31'h0, fan_full_speed_o});
        rd("pin status", ad(TOFC_IDX_PIN_STAT), 32'h4);
        ext_low <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        wrap_up();
    end
endmodule
`default_nettype wire
